// [rtl/crypt_consts.svh]
/*
  Register offsets, field positions, reset values and cycle counts of
  the block cipher engine.
  Assumes inclusion by bare name wherever these constants are needed.
*/
`ifndef CRYPT_CONSTS_SVH
`define CRYPT_CONSTS_SVH

// word registers, byte addresses on the 12-bit apb address
`define OFS_CONTROL     12'h000
`define OFS_CONFIG      12'h004
`define OFS_STATUS      12'h008
`define OFS_INT_MASK    12'h00c
// windows of several words, compared on the upper address bits
`define BASE_KEY        7'h01
`define BASE_TEXT_A     8'h04
`define BASE_TEXT_B     8'h05
`define BASE_CHAIN      8'h06

// control_low_register fields
`define CTL_ENABLE      15
`define CTL_IDLE_STOP   13
`define CTL_FREE_IE     10
`define CTL_DONE_IE     9
`define CTL_GO          8
`define CTL_OPSEL_LSB   0

// configuration register fields
`define CFG_CIPHER      0
`define CFG_CHAIN_LSB   1
`define CFG_KEYLEN_LSB  4
`define CFG_KEYSRC_LSB  8

// status and interrupt mask share this layout
`define ST_FAIL         0
`define ST_DONE         1
`define ST_FREE         2

// reset values
`define RST_NEED_EXPAND 1'b1
`define RST_WORD        32'h0000_0000

// cycle counts of the datapath
`define EXPAND_CYCLES   4'h8
`define ROUND_LAST      4'hf

`endif

// [rtl/crypt_pkg.sv]
/*
  Types and helper functions of the block cipher engine.
  Assumes nothing beyond the compile order: this file comes first.
*/
package crypt_pkg;

  typedef enum logic [3:0] {
    OP_ENCRYPT   = 4'h0,
    OP_DECRYPT   = 4'h1,
    OP_EXPAND    = 4'h2,
    OP_KEY_STORE = 4'h3
  } op_t;

  // gray codes along idle, expand, run, done
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_EXPAND = 2'b01,
    ST_RUN    = 2'b11,
    ST_DONE   = 2'b10
  } eng_state_t;

  typedef enum logic [1:0] {
    CH_ECB = 2'h0,
    CH_CBC = 2'h1
  } chain_t;

  typedef enum logic [1:0] {
    KL_BASE = 2'h0,
    KL_192  = 2'h1,
    KL_256  = 2'h2
  } keylen_t;

  typedef enum logic [1:0] {
    KS_SOFTWARE = 2'h0,
    KS_STORED   = 2'h1
  } keysrc_t;

  typedef struct packed {
    logic         busy;
    logic [3:0]   cnt;
    logic [127:0] acc;
    logic         done;
  } kx_t;

  typedef struct packed {
    logic         busy;
    logic         decrypt;
    logic         des;
    logic [3:0]   rnd;
    logic [127:0] x;
    logic         done;
  } bd_t;

  typedef struct packed {
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
    logic              enable;
    logic              idle_stop;
    logic              free_ie;
    logic              done_ie;
    logic              go;
    logic [3:0]        opsel;
    logic              cipher;
    logic [1:0]        chain;
    logic [1:0]        keylen;
    logic [1:0]        keysrc;
    logic              fail;
    logic              done_flag;
    logic              free_flag;
    logic              need_expand;
    logic [1:0]        last_keylen;
    logic [1:0]        last_keysrc;
    logic [7:0][31:0]  key;
    logic [7:0][31:0]  key_store;
    logic [3:0][31:0]  text_a;
    logic [3:0][31:0]  text_b;
    logic [3:0][31:0]  chain_reg;
    eng_state_t        st;
    logic [3:0]        run_op;
    logic [127:0]      run_in;
    logic              exp_start;
    logic              blk_start;
  } core_t;

  // block width: 64 bits for des (cipher 0), 128 bits for aes
  function automatic logic [127:0] blk_mask(input logic des);
    blk_mask = des ? {64'h0, {64{1'b1}}} : {128{1'b1}};
  endfunction : blk_mask

  // one-bit rotations inside the live lane of the block
  function automatic logic [127:0] rot_l(input logic [127:0] v,
                                         input logic         des);
    rot_l = des ? {64'h0, v[62:0], v[63]} : {v[126:0], v[127]};
  endfunction : rot_l

  function automatic logic [127:0] rot_r(input logic [127:0] v,
                                         input logic         des);
    rot_r = des ? {64'h0, v[0], v[63:1]} : {v[0], v[127:1]};
  endfunction : rot_r

endpackage : crypt_pkg

// [rtl/key_expander.sv]
/*
  Multi-cycle key schedule unit: folds the masked key into a schedule.
  Assumes a one-cycle start pulse while idle and a key stable until done.
*/
`timescale 1ns/10ps
`include "crypt_consts.svh"

module key_expander
  import crypt_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         start,
  input  wire logic         hold,
  input  wire logic [255:0] key_in,
  output logic              done,
  output logic [127:0]      sched_key
);

  kx_t s;
  kx_t next_s;

  // schedule mixes rotation and step count; hold freezes it in idle stop
  always_comb begin : next_logic
    next_s      = s;
    // done stands while frozen, else a stalled sequencer would miss it
    next_s.done = s.done && hold;                               // [R16]
    if (start) begin
      next_s.busy = 1'b1;
      next_s.cnt  = `EXPAND_CYCLES;
      next_s.acc  = key_in[127:0] ^ key_in[255:128];
    end else if (s.busy && !hold) begin
      next_s.acc = {s.acc[124:0], s.acc[127:125]} ^ {124'h0, s.cnt};
      if (s.cnt == 4'h1) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.cnt = s.cnt - 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin : state_reg
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done      = s.done;
  assign sched_key = s.acc;

endmodule : key_expander

// [rtl/block_decipher.sv]
/*
  Round-iterated block datapath, encrypt or decrypt direction.
  Assumes a one-cycle start pulse while idle and a stable schedule key.
*/
`timescale 1ns/10ps
`include "crypt_consts.svh"

module block_decipher
  import crypt_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         start,
  input  wire logic         hold,
  input  wire logic         decrypt,
  input  wire logic         des,
  input  wire logic [127:0] rkey,
  input  wire logic [127:0] din,
  output logic              done,
  output logic [127:0]      dout
);

  bd_t          s;
  bd_t          next_s;
  logic [255:0] rk_wide;
  logic [127:0] rk;

  // decrypt walks the rounds backwards so it undoes encrypt exactly
  always_comb begin : next_logic
    next_s      = s;
    // done stands while frozen, else a stalled sequencer would miss it
    next_s.done = s.done && hold;                               // [R16]
    rk_wide     = {rkey, rkey} << s.rnd;
    rk          = rk_wide[255:128] & blk_mask(s.des);
    if (start) begin
      next_s.busy    = 1'b1;
      next_s.decrypt = decrypt;
      next_s.des     = des;
      next_s.rnd     = decrypt ? `ROUND_LAST : 4'h0;
      next_s.x       = din & blk_mask(des);
    end else if (s.busy && !hold) begin
      if (s.decrypt) begin
        next_s.x   = rot_r(s.x, s.des) ^ rk;
        next_s.rnd = s.rnd - 4'h1;
      end else begin
        next_s.x   = rot_l(s.x ^ rk, s.des);
        next_s.rnd = s.rnd + 4'h1;
      end
      if (s.rnd == (s.decrypt ? 4'h0 : `ROUND_LAST)) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin : state_reg
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign dout = s.x;

endmodule : block_decipher

// [rtl/crypt_engine.sv]
/*
  Block cipher engine: apb register file, run sequencer, key storage,
  chaining, interrupt flags; instantiates key_expander, block_decipher.
  Assumes an apb3 master on pclk and device_idle synchronous to pclk.
*/
// The APB register port and the placing of the registers are this design's own decisions.
// Notes on behaviour
// [R1] software sets engine_enable before go; go is refused otherwise (code checks only the enable bit written together with go)
// [R2] software programs cipher, chaining, key length and source first
// [R3] operation_select code 0001 selects decrypt
// [R4] only the lowest n key bits are used for key length n
// [R5] software runs the expansion operation before first aes decrypt
// [R6] illegal configuration raises the fail flag and the run is refused
// [R7] des input comes only from the lowest 64 bits of text register b
// [R8] go starts the run, stays set while busy, clears at completion
// [R9] fresh expansion after reset, key store, or key mode/source change
// [R10] free interrupt enable at control bit 10 flags text reload
// [R11] completion raises done flag; interrupt only with done enable
// [R12] with several sources enabled, software reads go to tell done
// [R13] software reads the result; later blocks skip reconfiguration
// [R14] operation_select code 0000 selects encrypt
// [R15] blocks are 64 bits for des and 128 bits for aes
// [R16] idle stop 0 runs on in device idle; 1 freezes as in sleep
// [R17] configuration and key writes are ignored while go is set
`timescale 1ns/10ps
`include "crypt_consts.svh"

module crypt_engine
  import crypt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        device_idle,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  core_t          s;
  core_t          next_s;
  logic           exp_done;
  logic [127:0]   sched_key;
  logic           blk_done;
  logic [127:0]   blk_out;
  logic           stall;
  logic           busy;
  logic           des;
  logic [255:0]   key_used;
  logic [127:0]   din;
  logic [127:0]   result;
  logic           hit;
  logic [31:0]    rd;
  logic [3:0]     w_op;
  logic           go_req;
  logic           expand_req;
  logic           is_crypt;

  // configuration check shared by the live flag and the go request
  function automatic logic cfg_bad(input logic       cipher,
                                   input logic [1:0] chain,
                                   input logic [1:0] keylen,
                                   input logic [1:0] keysrc,
                                   input logic [3:0] op);
    cfg_bad = (chain > CH_CBC) || (keysrc > KS_STORED) ||
              (op > OP_KEY_STORE) ||
              (cipher ? (keylen > KL_256) : (keylen != KL_BASE));
  endfunction : cfg_bad

  // lowest n bits of the key survive, n from cipher and key length
  function automatic logic [255:0] key_mask(input logic       cipher,
                                            input logic [1:0] keylen);
    if (!cipher) begin
      key_mask = {192'h0, {64{1'b1}}};
    end else if (keylen == KL_192) begin
      key_mask = {64'h0, {192{1'b1}}};
    end else if (keylen == KL_256) begin
      key_mask = {256{1'b1}};
    end else begin
      key_mask = {128'h0, {128{1'b1}}};
    end
  endfunction : key_mask

  key_expander u_expander (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (s.exp_start),
    .hold      (stall),
    .key_in    (key_used),
    .done      (exp_done),
    .sched_key (sched_key)
  );

  block_decipher u_datapath (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (s.blk_start),
    .hold    (stall),
    .decrypt (s.run_op == OP_DECRYPT),
    .des     (!s.cipher),
    .rkey    (sched_key),
    .din     (s.run_in),
    .done    (blk_done),
    .dout    (blk_out)
  );

  // datapath views and read mux
  always_comb begin : datapath_view
    stall    = s.idle_stop && device_idle;                      // [R16]
    busy     = s.go;
    des      = !s.cipher;
    key_used = (s.keysrc == KS_STORED) ? s.key_store : s.key;
    key_used = key_used & key_mask(s.cipher, s.keylen);         // [R4]
    din      = s.text_b & blk_mask(des);                        // [R7] [R15]
    if (s.chain == CH_CBC && s.run_op == OP_ENCRYPT) begin
      result = blk_out;
    end else if (s.chain == CH_CBC) begin
      result = (blk_out ^ s.chain_reg) & blk_mask(des);
    end else begin
      result = blk_out;
    end
    hit = 1'b1;
    rd  = `RST_WORD;
    if (paddr == `OFS_CONTROL) begin
      rd[`CTL_ENABLE]    = s.enable;
      rd[`CTL_IDLE_STOP] = s.idle_stop;
      rd[`CTL_FREE_IE]   = s.free_ie;
      rd[`CTL_DONE_IE]   = s.done_ie;
      rd[`CTL_GO]        = s.go;                                // [R8]
      rd[`CTL_OPSEL_LSB+:4] = s.opsel;
    end else if (paddr == `OFS_CONFIG) begin
      rd[`CFG_CIPHER]       = s.cipher;
      rd[`CFG_CHAIN_LSB+:2] = s.chain;
      rd[`CFG_KEYLEN_LSB+:2] = s.keylen;
      rd[`CFG_KEYSRC_LSB+:2] = s.keysrc;
    end else if (paddr == `OFS_STATUS) begin
      rd[`ST_FAIL] = s.fail;
      rd[`ST_DONE] = s.done_flag;
      rd[`ST_FREE] = s.free_flag;
    end else if (paddr == `OFS_INT_MASK) begin
      rd[`ST_DONE] = s.done_ie;
      rd[`ST_FREE] = s.free_ie;
    end else if (paddr[11:5] == `BASE_KEY) begin
      rd = 32'h0;  // key words are write-only so the key cannot leak
    end else if (paddr[11:4] == `BASE_TEXT_A) begin
      rd = s.text_a[paddr[3:2]];
    end else if (paddr[11:4] == `BASE_TEXT_B) begin
      rd = s.text_b[paddr[3:2]];
    end else if (paddr[11:4] == `BASE_CHAIN) begin
      rd = s.chain_reg[paddr[3:2]];
    end else begin
      hit = 1'b0;
    end
  end

  // bus slave, go request, sequencer, flags; events set after clears
  always_comb begin : next_logic
    next_s           = s;
    next_s.exp_start = 1'b0;
    next_s.blk_start = 1'b0;
    w_op             = pwdata[`CTL_OPSEL_LSB+:4];
    go_req           = 1'b0;
    expand_req       = s.need_expand || (s.keylen != s.last_keylen) ||
                       (s.keysrc != s.last_keysrc);             // [R9]
    is_crypt         = (w_op == OP_DECRYPT) || (w_op == OP_ENCRYPT);
    // one wait state: pready rises one cycle into the access phase
    if (psel && penable && !s.pready) begin
      next_s.pready  = 1'b1;
      next_s.prdata  = rd;
      next_s.pslverr = !hit;
    end else if (psel && penable) begin
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      if (!pwrite && paddr == `OFS_STATUS) begin
        // clear only what the read reported, so a later event survives
        next_s.done_flag = s.done_flag && !s.prdata[`ST_DONE];
        next_s.free_flag = s.free_flag && !s.prdata[`ST_FREE];
      end
      if (pwrite && paddr == `OFS_CONTROL) begin
        next_s.idle_stop = pwdata[`CTL_IDLE_STOP];
        next_s.free_ie   = pwdata[`CTL_FREE_IE];                // [R10]
        next_s.done_ie   = pwdata[`CTL_DONE_IE];
        if (!busy) begin                                        // [R17]
          next_s.enable = pwdata[`CTL_ENABLE];
          next_s.opsel  = w_op;
          go_req = pwdata[`CTL_GO] && pwdata[`CTL_ENABLE] &&    // [R1]
                   !cfg_bad(s.cipher, s.chain, s.keylen,
                            s.keysrc, w_op);                    // [R6]
        end
      end
      if (pwrite && paddr == `OFS_INT_MASK) begin
        next_s.free_ie = pwdata[`ST_FREE];
        next_s.done_ie = pwdata[`ST_DONE];
      end
      if (pwrite && !busy) begin                                // [R17]
        if (paddr == `OFS_CONFIG) begin
          next_s.cipher = pwdata[`CFG_CIPHER];
          next_s.chain  = pwdata[`CFG_CHAIN_LSB+:2];
          next_s.keylen = pwdata[`CFG_KEYLEN_LSB+:2];
          next_s.keysrc = pwdata[`CFG_KEYSRC_LSB+:2];
        end else if (paddr[11:5] == `BASE_KEY) begin
          next_s.key[paddr[4:2]] = pwdata;
        end else if (paddr[11:4] == `BASE_TEXT_A) begin
          next_s.text_a[paddr[3:2]] = pwdata;
        end else if (paddr[11:4] == `BASE_TEXT_B) begin
          next_s.text_b[paddr[3:2]] = pwdata;
        end else if (paddr[11:4] == `BASE_CHAIN) begin
          next_s.chain_reg[paddr[3:2]] = pwdata;
        end
      end
    end
    // accepted go: latch the operation and its input block
    if (go_req) begin
      next_s.go     = 1'b1;                                     // [R8]
      next_s.run_op = w_op;
      if (w_op == OP_KEY_STORE) begin
        next_s.key_store   = s.key;
        next_s.need_expand = 1'b1;                              // [R9]
        next_s.st          = ST_DONE;
      end else if (!is_crypt || expand_req) begin
        next_s.st        = ST_EXPAND;                           // [R5] [R9]
        next_s.exp_start = 1'b1;
      end else begin
        next_s.st        = ST_RUN;
        next_s.blk_start = 1'b1;
      end
      if (is_crypt) begin
        next_s.run_in = (s.chain == CH_CBC && w_op == OP_ENCRYPT) ?
                        (din ^ s.chain_reg) & blk_mask(des) : din;
        next_s.free_flag = 1'b1;                                // [R10]
      end
    end
    // sequencer, frozen while idle stop holds the engine
    if (!stall) begin                                           // [R16]
      unique case (s.st)
        ST_IDLE: begin
        end
        ST_EXPAND: begin
          if (exp_done) begin
            next_s.need_expand = 1'b0;                          // [R9]
            next_s.last_keylen = s.keylen;
            next_s.last_keysrc = s.keysrc;
            if (s.run_op == OP_EXPAND) begin
              next_s.st = ST_DONE;
            end else begin
              next_s.st        = ST_RUN;
              next_s.blk_start = 1'b1;
            end
          end
        end
        ST_RUN: begin
          if (blk_done) begin
            next_s.text_a = result & blk_mask(des);             // [R15]
            if (s.chain == CH_CBC) begin
              next_s.chain_reg = (s.run_op == OP_DECRYPT) ?     // [R3] [R14]
                                 s.run_in : blk_out;
            end
            next_s.st = ST_DONE;
          end
        end
        ST_DONE: begin
          next_s.go        = 1'b0;                              // [R8] [R9]
          next_s.done_flag = 1'b1;                              // [R11]
          next_s.st        = ST_IDLE;
        end
      endcase
    end
    next_s.fail = cfg_bad(next_s.cipher, next_s.chain, next_s.keylen,
                          next_s.keysrc, next_s.opsel);         // [R6]
    next_s.irq  = (next_s.done_flag && next_s.done_ie) ||       // [R11]
                  (next_s.free_flag && next_s.free_ie);         // [R10]
  end

  // one register for all engine state; key expansion is owed after reset
  always_ff @(posedge pclk or negedge presetn) begin : state_reg
    if (!presetn) begin
      s             <= '0;
      s.need_expand <= `RST_NEED_EXPAND;                        // [R9]
    end else begin
      s <= next_s;
    end
  end

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign irq     = s.irq;

endmodule : crypt_engine

// [verif/crypt_engine_checker.sv]
/* port checker of crypt_engine: apb timing, decode, irq clearing.
   assumes a bind onto the top and word-aligned addresses. */
`timescale 1ns/10ps
module crypt_engine_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        device_idle,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  logic mapped;
  logic key_word;
  // word decode; the hole at 0x010 must answer with an error
  assign mapped   = paddr[11:4] <= 8'h06 && paddr[11:4] != 8'h01;
  assign key_word = paddr[11:5] == 7'h01;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready not one cycle into access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  unmapped_err_a: assert property (pready && !mapped |-> pslverr
    && prdata == 32'h0) else $error("unmapped not refused");
  mapped_ok_a: assert property (pready && mapped |-> !pslverr)
    else $error("mapped address refused");
  key_hidden_a: assert property (
    pready && !pwrite && key_word |-> prdata == 32'h0)
    else $error("key word readable");
  irq_clear_a: assert property (
    $fell(irq) |-> $past(pready) || $past(pready, 2))
    else $error("irq fell with no access");
  reset_quiet_a: assert property (!$past(presetn) |-> !irq && !pready)
    else $error("outputs busy after reset");
  cover property (pslverr);
  cover property ($rose(irq));
  cover property (pready && !pwrite && key_word);
endmodule : crypt_engine_checker

bind crypt_engine crypt_engine_checker checker_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .device_idle, .prdata, .pready, .pslverr, .irq
);

// [verif/tb_crypt_engine.sv]
/* self-checking bench of crypt_engine: round trips, run timing,
   refusals, interrupts, idle freeze. assumes the bound checker. */
`timescale 1ns/10ps
module tb_crypt_engine;
  logic        pclk, presetn, psel, penable, pwrite, device_idle;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic        pready, pslverr, irq, err_q;
  logic [31:0] pt [4];
  logic [31:0] ct [4];
  int          n_fail, compares, cyc, t0, seed;

  crypt_engine uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .device_idle, .prdata, .pready, .pslverr, .irq
  );

  // 8 ns clock
  always #4 pclk = ~pclk;

  // cycle count, also the hang limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      $display("mismatch %0t: timeout", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // idle cycle first, so psel is never set twice in one step
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q  = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask : rdc

  // enable and go are always set; c adds opcode and enables
  task automatic go(input logic [31:0] c);
    xfer(1'b1, 12'h000, 32'h8100 | c);
    t0 = cyc;
  endtask : go

  // irq needs done enable; run length is counted from the go edge
  task automatic fin(input int lo, input int slack, input logic [31:0] st);
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge pclk);
    chk(32'(cyc - t0 >= lo && cyc - t0 <= lo + slack), 32'h1);
    rdc(12'h008, st);
  endtask : fin

  // edges from the go edge until irq is seen: opcode, expansion owed
  function automatic int exp_len(input logic [3:0] op, input logic ex);
    if (op == 4'h3)
      return 2;
    else if (op == 4'h2)
      return 12;
    else
      return ex ? 30 : 20;
  endfunction : exp_len

  task automatic wtxt(input logic [31:0] w [4]);
    for (int i = 0; i < 4; i++) xfer(1'b1, 12'(80 + 4 * i), w[i]);
  endtask : wtxt

  task automatic wkey(input int from);
    for (int i = from; i < 8; i++)
      xfer(1'b1, 12'(32 + 4 * i), $random(seed));
  endtask : wkey

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    device_idle = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_fail = 0;
    compares = 0;
    cyc = 0;
    seed = 48922;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 16; a += 4) rdc(12'(a), 32'h0);
    xfer(1'b0, 12'h010, 32'h0);
    chk(32'(err_q), 32'h1);
    xfer(1'b1, 12'h07c, 32'h1);
    chk(32'(err_q), 32'h1);
    wkey(0);
    rdc(12'h020, 32'h0);
    // des then aes round trip; upper key bits change in between
    // expansion alone raises no free event, so status shows done only
    for (int c = 0; c < 2; c++) begin
      xfer(1'b1, 12'h004, 32'(c));
      if (c == 1) go(32'h202);
      if (c == 1) fin(exp_len(4'h2, 1'b0), 1, 32'h2);
      for (int i = 0; i < 4; i++) pt[i] = $random(seed);
      wtxt(pt);
      go(32'h200);
      fin(exp_len(4'h0, c == 0), 1, 32'h6);
      for (int i = 0; i < 4; i++) begin
        xfer(1'b0, 12'(64 + 4 * i), 32'h0);
        if (c == 0 && i > 1) chk(rd_q, 32'h0);
        ct[i] = (c == 0 && i > 1) ? $random(seed) : rd_q;
      end
      wkey(c ? 4 : 2);
      go(32'h202);
      fin(exp_len(4'h2, 1'b0), 1, 32'h2);
      wtxt(ct);
      go(32'h201);
      fin(exp_len(4'h1, 1'b0), 1, 32'h6);
      for (int i = 0; i < 4; i++)
        rdc(12'(64 + 4 * i), (c == 0 && i > 1) ? 32'h0 : pt[i]);
    end
    // chaining code 2 is illegal, so go must be refused
    xfer(1'b1, 12'h004, 32'h5);
    rdc(12'h008, 32'h1);
    go(32'h201);
    xfer(1'b0, 12'h000, 32'h0);
    chk(32'(rd_q[8]), 32'h0);
    rdc(12'h008, 32'h1);
    xfer(1'b1, 12'h004, 32'h3);
    rdc(12'h008, 32'h0);
    // go with the enable bit clear is refused as well
    xfer(1'b1, 12'h000, 32'h101);
    xfer(1'b0, 12'h000, 32'h0);
    chk(32'(rd_q[8]), 32'h0);
    xfer(1'b1, 12'h004, 32'h13);
    go(32'h201);
    fin(exp_len(4'h1, 1'b1), 1, 32'h6);
    go(32'h203);
    fin(exp_len(4'h3, 1'b0), 1, 32'h2);
    go(32'h201);
    fin(exp_len(4'h1, 1'b1), 1, 32'h6);
    // a key source change owes an expansion, and so does changing back
    xfer(1'b1, 12'h004, 32'h113);
    go(32'h201);
    fin(exp_len(4'h1, 1'b1), 1, 32'h6);
    xfer(1'b1, 12'h004, 32'h13);
    go(32'h201);
    fin(exp_len(4'h1, 1'b1), 1, 32'h6);
    // config write during a run is ignored; idle stop 0 runs on
    device_idle <= 1'b1;
    go(32'h201);
    xfer(1'b1, 12'h004, 32'h21);
    fin(exp_len(4'h1, 1'b0), 1, 32'h6);
    rdc(12'h004, 32'h13);
    go(32'h2201);
    repeat (40) @(posedge pclk);
    xfer(1'b0, 12'h000, 32'h0);
    chk(32'(rd_q[8]), 32'h1);
    device_idle <= 1'b0;
    fin(60, 10, 32'h6);
    // done stays silent until unmasked
    go(32'h001);
    repeat (30) @(posedge pclk);
    chk(32'(irq), 32'h0);
    xfer(1'b1, 12'h00c, 32'h2);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    rdc(12'h008, 32'h6);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    go(32'h401);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h1);
    xfer(1'b0, 12'h000, 32'h0);
    chk(32'(rd_q[8]), 32'h1);
    repeat (30) @(posedge pclk);
    rdc(12'h008, 32'h6);
    end_of_test();
  end
endmodule : tb_crypt_engine
